// [src/dag_defines.svh]
// Constants for the data address generation block
`ifndef DAG_DEFINES_SVH
`define DAG_DEFINES_SVH

// Data space: 32K words, 64 Kbytes, byte addressed
`define DAG_DATA_AW        16
`define DAG_DATA_WORDS     32768
`define DAG_WORD_STEP      16'h0002
`define DAG_BYTE_STEP      16'h0001
`define DAG_LSB_CLEAR      16'hFFFE

// Working registers
`define DAG_NUM_WREG       16
`define DAG_STACK_IDX      4'hF
`define DAG_WREG_RST       16'h0000
`define DAG_STACK_RST      16'h0800

// Program space
`define DAG_PGM_AW         24
`define DAG_PSV_BIT        15
`define DAG_TBL_CFG_BIT    7
`define DAG_PGM_RST        24'h000000

// Default X/Y split point; arbitrary value, set per device
`define DAG_Y_BASE_DEF     16'h0900

`endif

// [src/dag_pkg.sv]
// Types shared by the data address generation block
package dag_pkg;

  typedef enum logic [5:0] {
    MODE_PLAIN    = 6'h01,
    MODE_POST_INC = 6'h02,
    MODE_POST_DEC = 6'h04,
    MODE_PRE_INC  = 6'h08,
    MODE_PRE_DEC  = 6'h10,
    MODE_REG_OFS  = 6'h20
  } dag_mode_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] ptr;
    dag_mode_t  mode;
    logic       byte_op;
    logic [3:0] ofs_idx;
  } dag_req_t;

  typedef struct packed {
    logic        en;
    logic [3:0]  sel;
    logic [15:0] start;
    logic [15:0] stop;
  } dag_modulo_control_t;

  typedef struct packed {
    logic        bitrev_enable;
    logic [3:0]  bitrev_pointer_select;
    logic [14:0] bitrev_pivot;
  } dag_bitrev_control_t;

  typedef struct packed {
    logic [15:0] mod_addr;
    logic        dec;
    logic        use_mod;
    logic        wb;
  } dag_calc_t;

endpackage

// [src/dag_modulo.sv]
// Circular buffer boundary correction for one address unit
`timescale 1ns/10ps
`include "dag_defines.svh"

module dag_modulo (
  input  wire logic        en_i,
  input  wire logic        dec_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] start_i,
  input  wire logic [15:0] stop_i,
  output logic      [15:0] addr_o
);

  logic [15:0] len;

  // Compares beyond the bound, not just equality, so large steps still wrap
  always_comb
  begin
    len    = 16'(stop_i - start_i + 16'h0001);
    addr_o = addr_i;
    if (en_i && !dec_i && (addr_i > stop_i))
    begin
      addr_o = 16'(addr_i - len); // RQ15
    end
    else if (en_i && dec_i && (addr_i < start_i))
    begin
      addr_o = 16'(addr_i + len); // RQ15
    end
  end

endmodule

// [src/dag_bitrev.sv]
// Reverse-carry pointer update for bit-reversed writes
`timescale 1ns/10ps
`include "dag_defines.svh"

module dag_bitrev (
  input  wire logic [15:0] ptr_i,
  input  wire logic [14:0] pivot_i,
  output logic      [15:0] addr_o
);

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  logic [15:0] sum;

  // Pointer and modifier are reversed for the add and the sum reversed back; ports stay in normal order
  always_comb
  begin
    sum    = 16'(rev16(ptr_i) + rev16({pivot_i, 1'b0})); // RQ19 RQ20 RQ22
    addr_o = rev16(sum) & `DAG_LSB_CLEAR; // RQ23
  end

endmodule

// [src/dag_top.sv]
// Data space address generation: X/Y units, working registers, program mapping
// How it works
// RQ1: Data space is 16-bit byte addresses, 64 Kbytes or 32K words.
// RQ2: X and Y memory blocks each get their own address unit.
// RQ3: General instructions use only the X unit over one linear space.
// RQ4: Dual-operand instructions read X and Y together, splitting the space.
// RQ5: X/Y boundary is a module parameter, not fixed.
// RQ6: Circular addressing works in both X and Y units.
// RQ7: X circular addressing is available to every general instruction.
// RQ8: Upper 32 Kbytes optionally map to program space at an 8-bit page.
// RQ9: Program addresses are 24 bits from PC, table access or mapping.
// RQ10: Normal user program access stays below 0x800000.
// RQ11: Table reads and writes reach configuration space via page bit 7.
// RQ12: Sixteen 16-bit working registers, usable as data, address or offset.
// RQ13: Register fifteen is the stack pointer for calls and interrupts.
// RQ14: Circular correction may apply to any working register's address.
// RQ15: Wrap when overshooting upper bound rising or lower bound falling.
// RQ16: Corrected address is written back only for pre/post modify modes.
// RQ17: Register-plus-offset gets corrected address, pointer left unchanged.
// RQ18: Bit reversal exists only in the X unit and only for writes.
// RQ19: In bit reversal the modifier is treated with reversed bit order.
// RQ20: Pointer and result addresses stay in normal bit order.
// RQ21: Bit reversal needs pointer not 15, enable set, pre/post increment.
// RQ22: Bit reversal adds the byte-scaled 15-bit pivot, ignoring mode offset.
// RQ23: Byte data or other modes get normal addresses; EA LSB forced low.
// RQ24: Bit reversal beats modulo in X write and Y, not in X read.
// RQ25: Buffer bounds and pointer selects arrive as configuration inputs.
`timescale 1ns/10ps
`include "dag_defines.svh"

module dag_top #(
  parameter logic [15:0] Y_BASE = `DAG_Y_BASE_DEF
) (
  input  wire logic                         CLK_SYS_I,
  input  wire logic                         RESETN_I,
  input  wire dag_pkg::dag_req_t            X_RD_REQ_I,
  input  wire dag_pkg::dag_req_t            X_WR_REQ_I,
  input  wire dag_pkg::dag_req_t            Y_RD_REQ_I,
  input  wire logic                         DUAL_OP_I,
  input  wire dag_pkg::dag_modulo_control_t X_MOD_CFG_I,
  input  wire dag_pkg::dag_modulo_control_t Y_MOD_CFG_I,
  input  wire dag_pkg::dag_bitrev_control_t BITREV_CFG_I,
  input  wire logic                         REG_WR_EN_I,
  input  wire logic [3:0]                   REG_WR_IDX_I,
  input  wire logic [15:0]                  REG_WR_DATA_I,
  input  wire logic [3:0]                   REG_RD_IDX_I,
  input  wire logic                         STACK_PUSH_I,
  input  wire logic                         STACK_POP_I,
  input  wire logic                         PSV_EN_I,
  input  wire logic [7:0]                   PSV_PAGE_I,
  input  wire logic [7:0]                   TBL_PAGE_I,
  input  wire logic                         TBL_RD_I,
  input  wire logic                         TBL_WR_I,
  input  wire logic [22:0]                  PC_I,
  output logic      [15:0]                  REG_RD_DATA_O,
  output logic      [15:0]                  SP_EA_O,
  output logic      [15:0]                  X_RD_EA_O,
  output logic                              X_RD_VALID_O,
  output logic      [15:0]                  X_WR_EA_O,
  output logic                              X_WR_VALID_O,
  output logic                              X_WR_BREV_O,
  output logic      [15:0]                  Y_RD_EA_O,
  output logic                              Y_RD_VALID_O,
  output logic                              SPLIT_ERR_O,
  output logic      [23:0]                  PGM_ADDR_O,
  output logic                              PGM_PSV_O,
  output logic                              PGM_TBL_RD_O,
  output logic                              PGM_TBL_WR_O,
  output logic                              PGM_CFG_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Shared address arithmetic for every unit

  function automatic dag_pkg::dag_calc_t unit_calc(input dag_pkg::dag_req_t r,
                                                  input logic [15:0] base,
                                                  input logic [15:0] ofsv);
    dag_pkg::dag_calc_t c;
    logic [15:0]        step;
    step = r.byte_op ? `DAG_BYTE_STEP : `DAG_WORD_STEP;
    c    = '{mod_addr: base, dec: 1'b0, use_mod: 1'b0, wb: 1'b0};
    case (r.mode)
      dag_pkg::MODE_PLAIN:    c = '{base, 1'b0, 1'b0, 1'b0};
      dag_pkg::MODE_POST_INC: c = '{16'(base + step), 1'b0, 1'b0, 1'b1};
      dag_pkg::MODE_POST_DEC: c = '{16'(base - step), 1'b1, 1'b0, 1'b1};
      dag_pkg::MODE_PRE_INC:  c = '{16'(base + step), 1'b0, 1'b1, 1'b1};
      dag_pkg::MODE_PRE_DEC:  c = '{16'(base - step), 1'b1, 1'b1, 1'b1};
      dag_pkg::MODE_REG_OFS:  c = '{16'(base + ofsv), ofsv[15], 1'b1, 1'b0};
      default:                c = '{base, 1'b0, 1'b0, 1'b0};
    endcase
    return c;
  endfunction

  function automatic logic is_inc(input dag_pkg::dag_mode_t m);
    return (m == dag_pkg::MODE_PRE_INC) || (m == dag_pkg::MODE_POST_INC);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [15:0] wreg_ff [`DAG_NUM_WREG];
  logic [15:0] nxt_wreg [`DAG_NUM_WREG];
  logic [15:0] x_rd_ea_ff, nxt_x_rd_ea, x_wr_ea_ff, nxt_x_wr_ea;
  logic [15:0] y_rd_ea_ff, nxt_y_rd_ea, sp_ea_ff, nxt_sp_ea;
  logic        x_rd_vld_ff, nxt_x_rd_vld, x_wr_vld_ff, nxt_x_wr_vld;
  logic        y_rd_vld_ff, nxt_y_rd_vld, brev_ff, nxt_brev;
  logic        split_err_ff, nxt_split_err;
  logic [23:0] pgm_addr_ff, nxt_pgm_addr;
  logic        psv_ff, nxt_psv, tbl_rd_ff, nxt_tbl_rd;
  logic        tbl_wr_ff, nxt_tbl_wr, cfg_ff, nxt_cfg;

  dag_pkg::dag_calc_t xr_c, xw_c, y_c;
  logic [15:0] xr_base, xw_base, y_base, xr_cor, xw_cor, y_cor, brev_addr;
  logic [15:0] xr_ea, xw_ea, y_ea, xw_new;
  logic        brev_act, brev_block, xr_men, xw_men, y_men;

  ////////////////////////////////////////////////////////////////////////////
  // Address units

  always_comb
  begin
    xr_base = wreg_ff[X_RD_REQ_I.ptr];
    xw_base = wreg_ff[X_WR_REQ_I.ptr];
    y_base  = wreg_ff[Y_RD_REQ_I.ptr];
    xr_c    = unit_calc(X_RD_REQ_I, xr_base, wreg_ff[X_RD_REQ_I.ofs_idx]); // RQ2 RQ3
    xw_c    = unit_calc(X_WR_REQ_I, xw_base, wreg_ff[X_WR_REQ_I.ofs_idx]);
    y_c     = unit_calc(Y_RD_REQ_I, y_base, wreg_ff[Y_RD_REQ_I.ofs_idx]); // RQ2
    // Stack register is never a reversed pointer
    brev_block = BITREV_CFG_I.bitrev_enable &&
                 (BITREV_CFG_I.bitrev_pointer_select != `DAG_STACK_IDX);
    brev_act   = brev_block && X_WR_REQ_I.valid && is_inc(X_WR_REQ_I.mode) &&
                 !X_WR_REQ_I.byte_op &&
                 (X_WR_REQ_I.ptr == BITREV_CFG_I.bitrev_pointer_select); // RQ18 RQ21
    xr_men  = X_MOD_CFG_I.en && (X_MOD_CFG_I.sel == X_RD_REQ_I.ptr); // RQ7 RQ14 RQ25
    xw_men  = X_MOD_CFG_I.en && (X_MOD_CFG_I.sel == X_WR_REQ_I.ptr) && !brev_block; // RQ24
    y_men   = Y_MOD_CFG_I.en && (Y_MOD_CFG_I.sel == Y_RD_REQ_I.ptr) && !brev_block; // RQ6 RQ24
  end

  dag_modulo u_mod_xr (
    .en_i    (xr_men),
    .dec_i   (xr_c.dec),
    .addr_i  (xr_c.mod_addr),
    .start_i (X_MOD_CFG_I.start),
    .stop_i  (X_MOD_CFG_I.stop),
    .addr_o  (xr_cor)
  );

  dag_modulo u_mod_xw (
    .en_i    (xw_men),
    .dec_i   (xw_c.dec),
    .addr_i  (xw_c.mod_addr),
    .start_i (X_MOD_CFG_I.start),
    .stop_i  (X_MOD_CFG_I.stop),
    .addr_o  (xw_cor)
  );

  dag_modulo u_mod_y (
    .en_i    (y_men),
    .dec_i   (y_c.dec),
    .addr_i  (y_c.mod_addr),
    .start_i (Y_MOD_CFG_I.start),
    .stop_i  (Y_MOD_CFG_I.stop),
    .addr_o  (y_cor)
  );

  dag_bitrev u_brev (
    .ptr_i   (xw_base),
    .pivot_i (BITREV_CFG_I.bitrev_pivot),
    .addr_o  (brev_addr)
  );

  always_comb
  begin
    xr_ea  = xr_c.use_mod ? xr_cor : xr_base;
    y_ea   = y_c.use_mod ? y_cor : y_base;
    xw_new = brev_act ? brev_addr : xw_cor; // RQ22
    if (brev_act)
    begin
      xw_ea = (xw_c.use_mod ? brev_addr : xw_base) & `DAG_LSB_CLEAR; // RQ23
    end
    else
    begin
      xw_ea = xw_c.use_mod ? xw_cor : xw_base; // RQ23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: register file, outputs, program addressing

  always_comb
  begin
    for (int i = 0; i < `DAG_NUM_WREG; i++)
    begin
      nxt_wreg[i] = wreg_ff[i];
    end
    if (REG_WR_EN_I)
    begin
      nxt_wreg[REG_WR_IDX_I] = REG_WR_DATA_I; // RQ12
    end
    // Later writers win when two units name the same pointer
    if (X_RD_REQ_I.valid && xr_c.wb)
    begin
      nxt_wreg[X_RD_REQ_I.ptr] = xr_cor; // RQ16 RQ17
    end
    if (X_WR_REQ_I.valid && xw_c.wb)
    begin
      nxt_wreg[X_WR_REQ_I.ptr] = xw_new; // RQ16
    end
    if (DUAL_OP_I && Y_RD_REQ_I.valid && y_c.wb)
    begin
      nxt_wreg[Y_RD_REQ_I.ptr] = y_cor; // RQ16
    end
    nxt_sp_ea = sp_ea_ff;
    if (STACK_PUSH_I)
    begin
      nxt_sp_ea                = wreg_ff[`DAG_STACK_IDX];
      nxt_wreg[`DAG_STACK_IDX] = 16'(wreg_ff[`DAG_STACK_IDX] + `DAG_WORD_STEP); // RQ13
    end
    else if (STACK_POP_I)
    begin
      nxt_sp_ea                = 16'(wreg_ff[`DAG_STACK_IDX] - `DAG_WORD_STEP);
      nxt_wreg[`DAG_STACK_IDX] = 16'(wreg_ff[`DAG_STACK_IDX] - `DAG_WORD_STEP); // RQ13
    end

    nxt_x_rd_vld  = X_RD_REQ_I.valid;
    nxt_x_rd_ea   = X_RD_REQ_I.valid ? xr_ea : x_rd_ea_ff; // RQ1
    nxt_x_wr_vld  = X_WR_REQ_I.valid;
    nxt_x_wr_ea   = X_WR_REQ_I.valid ? xw_ea : x_wr_ea_ff;
    nxt_brev      = brev_act;
    nxt_y_rd_vld  = DUAL_OP_I && Y_RD_REQ_I.valid; // RQ4
    nxt_y_rd_ea   = nxt_y_rd_vld ? y_ea : y_rd_ea_ff;
    // Split space: X operand below the boundary, Y at or above it
    nxt_split_err = DUAL_OP_I && ((Y_RD_REQ_I.valid && (y_ea < Y_BASE)) ||
                    (X_RD_REQ_I.valid && (xr_ea >= Y_BASE))); // RQ4 RQ5

    nxt_psv    = 1'b0;
    nxt_tbl_rd = TBL_RD_I;
    nxt_tbl_wr = TBL_WR_I;
    nxt_cfg    = 1'b0;
    if (TBL_RD_I || TBL_WR_I)
    begin
      nxt_pgm_addr = {TBL_PAGE_I, xr_ea}; // RQ9
      nxt_cfg      = TBL_PAGE_I[`DAG_TBL_CFG_BIT]; // RQ11
    end
    else if (PSV_EN_I && X_RD_REQ_I.valid && xr_ea[`DAG_PSV_BIT])
    begin
      nxt_pgm_addr = {1'b0, PSV_PAGE_I, xr_ea[14:0]}; // RQ8 RQ10
      nxt_psv      = 1'b1;
    end
    else
    begin
      nxt_pgm_addr = {1'b0, PC_I}; // RQ9 RQ10
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RESETN_I)
    begin
      for (int i = 0; i < `DAG_NUM_WREG; i++)
      begin
        wreg_ff[i] <= `DAG_WREG_RST;
      end
      wreg_ff[`DAG_STACK_IDX] <= `DAG_STACK_RST;
      x_rd_ea_ff   <= 16'h0000;
      x_wr_ea_ff   <= 16'h0000;
      y_rd_ea_ff   <= 16'h0000;
      sp_ea_ff     <= 16'h0000;
      x_rd_vld_ff  <= 1'b0;
      x_wr_vld_ff  <= 1'b0;
      y_rd_vld_ff  <= 1'b0;
      brev_ff      <= 1'b0;
      split_err_ff <= 1'b0;
      pgm_addr_ff  <= `DAG_PGM_RST;
      psv_ff       <= 1'b0;
      tbl_rd_ff    <= 1'b0;
      tbl_wr_ff    <= 1'b0;
      cfg_ff       <= 1'b0;
    end
    else
    begin
      wreg_ff      <= nxt_wreg;
      x_rd_ea_ff   <= nxt_x_rd_ea;
      x_wr_ea_ff   <= nxt_x_wr_ea;
      y_rd_ea_ff   <= nxt_y_rd_ea;
      sp_ea_ff     <= nxt_sp_ea;
      x_rd_vld_ff  <= nxt_x_rd_vld;
      x_wr_vld_ff  <= nxt_x_wr_vld;
      y_rd_vld_ff  <= nxt_y_rd_vld;
      brev_ff      <= nxt_brev;
      split_err_ff <= nxt_split_err;
      pgm_addr_ff  <= nxt_pgm_addr;
      psv_ff       <= nxt_psv;
      tbl_rd_ff    <= nxt_tbl_rd;
      tbl_wr_ff    <= nxt_tbl_wr;
      cfg_ff       <= nxt_cfg;
    end
  end

  assign REG_RD_DATA_O = wreg_ff[REG_RD_IDX_I];
  assign SP_EA_O       = sp_ea_ff;
  assign X_RD_EA_O     = x_rd_ea_ff;
  assign X_RD_VALID_O  = x_rd_vld_ff;
  assign X_WR_EA_O     = x_wr_ea_ff;
  assign X_WR_VALID_O  = x_wr_vld_ff;
  assign X_WR_BREV_O   = brev_ff;
  assign Y_RD_EA_O     = y_rd_ea_ff;
  assign Y_RD_VALID_O  = y_rd_vld_ff;
  assign SPLIT_ERR_O   = split_err_ff;
  assign PGM_ADDR_O    = pgm_addr_ff;
  assign PGM_PSV_O     = psv_ff;
  assign PGM_TBL_RD_O  = tbl_rd_ff;
  assign PGM_TBL_WR_O  = tbl_wr_ff;
  assign PGM_CFG_O     = cfg_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESETN_I);

  a_brev_lsb_low: assert property (X_WR_VALID_O && X_WR_BREV_O |-> !X_WR_EA_O[0]) // RQ23
    else $error("bit-reversed write address has LSB set");
  a_brev_no_byte: assert property (X_WR_REQ_I.valid && X_WR_REQ_I.byte_op |=> !X_WR_BREV_O) // RQ23
    else $error("bit reversal on byte write");
  a_brev_no_stack: assert property (X_WR_REQ_I.ptr == `DAG_STACK_IDX |=> !X_WR_BREV_O) // RQ21
    else $error("bit reversal on stack register");
  a_ofs_keeps_ptr: assert property (X_RD_REQ_I.valid && X_RD_REQ_I.mode == dag_pkg::MODE_REG_OFS
    && !REG_WR_EN_I && !X_WR_REQ_I.valid && !DUAL_OP_I && !STACK_PUSH_I && !STACK_POP_I
    |=> wreg_ff[$past(X_RD_REQ_I.ptr)] == $past(xr_base)) // RQ17
    else $error("offset mode changed pointer");
  a_post_ea_base: assert property (X_RD_REQ_I.valid && X_RD_REQ_I.mode == dag_pkg::MODE_POST_INC
    |=> X_RD_EA_O == $past(xr_base)) // RQ16
    else $error("post modify EA is not the old pointer");
  a_mod_inc_wrap: assert property (X_RD_REQ_I.valid && xr_men && !xr_c.dec && xr_c.use_mod &&
    X_RD_REQ_I.mode != dag_pkg::MODE_REG_OFS && xr_c.mod_addr == X_MOD_CFG_I.stop + 16'h0002
    |=> X_RD_EA_O == $past(X_MOD_CFG_I.start) + 16'h0001) // RQ15
    else $error("modulo wrap on increment is wrong");
  a_psv_map_page: assert property (PGM_PSV_O |-> PGM_ADDR_O[22:15] == $past(PSV_PAGE_I)
    && !PGM_ADDR_O[23]) // RQ8 RQ10
    else $error("program view mapping is wrong");
  a_user_low_half: assert property (!PGM_TBL_RD_O && !PGM_TBL_WR_O |-> !PGM_ADDR_O[23]) // RQ10
    else $error("user program access above lower half");
  a_tbl_cfg_bit: assert property (TBL_RD_I |=> PGM_CFG_O == $past(TBL_PAGE_I[7])) // RQ11
    else $error("table page bit 7 not reflected");
  a_sp_push_step: assert property (STACK_PUSH_I ##1 !STACK_PUSH_I && !STACK_POP_I
    |-> SP_EA_O == $past(wreg_ff[`DAG_STACK_IDX])) // RQ13
    else $error("push address is not the stack pointer");
  a_y_needs_dual: assert property (!DUAL_OP_I |=> !Y_RD_VALID_O) // RQ4
    else $error("Y unit active outside dual operand");

  c_brev_write: cover property (X_WR_VALID_O && X_WR_BREV_O);
  c_dual_read:  cover property (X_RD_VALID_O && Y_RD_VALID_O);
  c_psv_access: cover property (PGM_PSV_O);
  c_tbl_config: cover property (PGM_TBL_RD_O && PGM_CFG_O);

endmodule

// [bench/dag_mem_model.sv]
// Data memory model standing behind the X address units
`timescale 1ns/10ps
module dag_mem_model (
  input  wire logic        clk_i,
  input  wire logic        wr_v_i,
  input  wire logic [15:0] wr_ea_i,
  input  wire logic [15:0] wr_d_i,
  input  wire logic [15:0] rd_ea_i,
  output logic      [15:0] rd_d_o
);
  // Word array; byte address bit 0 is ignored on both ports
  logic [15:0] mem  [32768];
  logic        hit  [32768];
  logic [15:0] last = 16'h0000;

  always @(posedge clk_i)
  begin
    if (wr_v_i)
    begin
      mem[wr_ea_i[15:1]] <= wr_d_i;
      hit[wr_ea_i[15:1]] <= 1'b1;
    end
    last <= rd_d_o;
  end

  // Unwritten words show no kind default, only the inverse of last data
  always_comb rd_d_o = (hit[rd_ea_i[15:1]] === 1'b1) ? mem[rd_ea_i[15:1]] : ~last;
endmodule

// [bench/tb_dag_top.sv]
// Self-checking bench for the data address generation block
`timescale 1ns/10ps
module tb_dag_top;
  localparam logic [15:0] YB = 16'h1000;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  dag_pkg::dag_req_t x_rd = '0, x_wr = '0, y_rd = '0;
  dag_pkg::dag_modulo_control_t x_mod = '0, y_mod = '0;
  dag_pkg::dag_bitrev_control_t brc = '0;
  logic dual = 1'b0, wr_en = 1'b0, push = 1'b0, pop = 1'b0;
  logic psv_en = 1'b0, tbl_rd = 1'b0, tbl_wr = 1'b0;
  logic [3:0] wr_idx = '0, rd_idx = '0;
  logic [15:0] wr_data = '0;
  logic [7:0] psv_pg = '0, tbl_pg = '0;
  logic [22:0] pc = '0;
  logic [15:0] rd_data, sp_ea, xr_ea, xw_ea, yr_ea, mem_x;
  logic xr_v, xw_v, xw_br, yr_v, split, pg_psv, pg_trd, pg_twr, pg_cfg;
  logic [23:0] pgm;
  logic [15:0] w [16];
  logic [31:0] seed = 32'hD9EF7B8A;
  int error_cnt = 0;
  int checks = 0;
  dag_pkg::dag_mode_t mt [6] = '{dag_pkg::MODE_PLAIN, dag_pkg::MODE_POST_INC,
    dag_pkg::MODE_POST_DEC, dag_pkg::MODE_PRE_INC, dag_pkg::MODE_PRE_DEC, dag_pkg::MODE_REG_OFS};

  dag_top #(.Y_BASE(YB)) dag_top_inst (
    .CLK_SYS_I(clk_sys), .RESETN_I(resetn), .X_RD_REQ_I(x_rd), .X_WR_REQ_I(x_wr),
    .Y_RD_REQ_I(y_rd), .DUAL_OP_I(dual), .X_MOD_CFG_I(x_mod), .Y_MOD_CFG_I(y_mod),
    .BITREV_CFG_I(brc), .REG_WR_EN_I(wr_en), .REG_WR_IDX_I(wr_idx), .REG_WR_DATA_I(wr_data),
    .REG_RD_IDX_I(rd_idx), .STACK_PUSH_I(push), .STACK_POP_I(pop), .PSV_EN_I(psv_en),
    .PSV_PAGE_I(psv_pg), .TBL_PAGE_I(tbl_pg), .TBL_RD_I(tbl_rd), .TBL_WR_I(tbl_wr),
    .PC_I(pc), .REG_RD_DATA_O(rd_data), .SP_EA_O(sp_ea), .X_RD_EA_O(xr_ea),
    .X_RD_VALID_O(xr_v), .X_WR_EA_O(xw_ea), .X_WR_VALID_O(xw_v), .X_WR_BREV_O(xw_br),
    .Y_RD_EA_O(yr_ea), .Y_RD_VALID_O(yr_v), .SPLIT_ERR_O(split), .PGM_ADDR_O(pgm),
    .PGM_PSV_O(pg_psv), .PGM_TBL_RD_O(pg_trd), .PGM_TBL_WR_O(pg_twr), .PGM_CFG_O(pg_cfg));

  // Write data carries its own address so a read-back proves both EAs agree
  dag_mem_model dag_mem_model_inst (.clk_i(clk_sys), .wr_v_i(xw_v), .wr_ea_i(xw_ea),
    .wr_d_i(xw_ea ^ 16'h5A5A), .rd_ea_i(xr_ea), .rd_d_o(mem_x));

  always #5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] rev(input logic [15:0] a);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = a[15 - i];
    return r;
  endfunction

  // Reverse-carry add of the byte-scaled pivot
  function automatic logic [15:0] brv(input logic [15:0] p);
    return rev(rev(p) + rev({brc.bitrev_pivot, 1'b0})) & 16'hFFFE;
  endfunction

  function automatic logic [15:0] modf(input logic [15:0] a, input logic d,
                                       input dag_pkg::dag_modulo_control_t c);
    logic [15:0] n;
    n = c.stop - c.start + 16'h0001;
    if (!d && a > c.stop) return a - n;
    if (d && a < c.start) return a + n;
    return a;
  endfunction

  // Returns {ea, new pointer} without circular correction
  function automatic logic [31:0] nrm(input dag_pkg::dag_mode_t m, input logic [15:0] p,
                                      input logic b, input logic [15:0] o);
    logic [15:0] s;
    s = b ? 16'h0001 : 16'h0002;
    case (m)
      dag_pkg::MODE_POST_INC: return {p, p + s};
      dag_pkg::MODE_POST_DEC: return {p, p - s};
      dag_pkg::MODE_PRE_INC:  return {p + s, p + s};
      dag_pkg::MODE_PRE_DEC:  return {p - s, p - s};
      dag_pkg::MODE_REG_OFS:  return {p + o, p};
      default:                return {p, p};
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [3:0] i, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    wr_en = 1'b1;
    wr_idx = i;
    wr_data = d;
    @(posedge clk_sys);
    #1;
    wr_en = 1'b0;
    w[i] = d;
  endtask

  // Unit 0 X read, 1 X write, 2 Y read; offset register is always W0
  task automatic op(input logic [1:0] u, input logic [3:0] p, input dag_pkg::dag_mode_t m,
                    input logic b, input logic [15:0] ea, input logic [15:0] np, input logic br);
    dag_pkg::dag_req_t r;
    // Idle edge first, so a strobe is never dropped and raised in one step
    @(posedge clk_sys);
    #1;
    r = '{valid: 1'b1, ptr: p, mode: m, byte_op: b, ofs_idx: 4'h0};
    rd_idx = p;
    if (u == 2'h0) x_rd = r;
    else if (u == 2'h1) x_wr = r;
    else y_rd = r;
    @(posedge clk_sys);
    #1;
    x_rd.valid = 1'b0;
    x_wr.valid = 1'b0;
    y_rd.valid = 1'b0;
    if (u == 2'h0) chk({7'h00, xr_v, xr_ea}, {8'h01, ea});
    else if (u == 2'h1) chk({6'h00, xw_br, xw_v, xw_ea}, {6'h00, br, 1'b1, ea});
    else chk({6'h00, split, yr_v, dual ? yr_ea : ea},
             {6'h00, dual && ea < YB, dual, ea});
    if (u != 2'h2 || dual) w[p] = np;
    chk({8'h00, rd_data}, {8'h00, w[p]});
  endtask

  task automatic stk(input logic ps);
    logic [15:0] e;
    @(posedge clk_sys);
    #1;
    rd_idx = 4'hF;
    push = ps;
    pop = !ps;
    @(posedge clk_sys);
    #1;
    push = 1'b0;
    pop = 1'b0;
    e = ps ? w[15] : w[15] - 16'h0002;
    w[15] = ps ? w[15] + 16'h0002 : e;
    chk({sp_ea, 8'h00}, {e, 8'h00});
    chk({8'h00, rd_data}, {8'h00, w[15]});
  endtask

  task automatic pg(input logic [23:0] a, input logic [3:0] f);
    chk(pgm, a);
    chk({20'h0, pg_psv, pg_trd, pg_twr, pg_cfg}, {20'h0, f});
  endtask

  task automatic summarize;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    error_cnt++;
    summarize();
  end

  initial
  begin
    logic [3:0] p;
    logic [31:0] e;
    repeat (10) @(posedge clk_sys);
    #1;
    resetn = 1'b1;
    chk({16'h0, xr_v, xw_v, yr_v, split, pg_psv, pg_trd, pg_twr, pg_cfg}, 24'h0);
    for (int i = 0; i < 16; i++)
    begin
      w[i] = (i == 15) ? 16'h0800 : 16'h0000;
      rd_idx = i[3:0];
      #2;
      chk({8'h00, rd_data}, {8'h00, w[i]});
    end
    @(posedge clk_sys);
    #1;
    for (int k = 0; k < 24; k++)
    begin
      seed = lfsr(seed);
      p = 4'h1 + seed[3:0] % 4'hE;
      wr(4'h0, seed[31:16] & 16'hFFFE);
      wr(p, seed[15:0] & 16'hFFFE);
      e = nrm(mt[seed[10:8] % 3'h6], w[p], seed[11], w[0]);
      op({1'b0, seed[12]}, p, mt[seed[10:8] % 3'h6], seed[11], e[31:16], e[15:0], 1'b0);
    end
    x_mod = '{en: 1'b1, sel: 4'h3, start: 16'h1000, stop: 16'h101F};
    wr(4'h3, 16'h101E);
    op(2'h0, 4'h3, dag_pkg::MODE_POST_INC, 1'b0, 16'h101E,
       modf(16'h1020, 1'b0, x_mod), 1'b0);
    e[15:0] = modf(w[3] - 16'h0002, 1'b1, x_mod);
    op(2'h1, 4'h3, dag_pkg::MODE_PRE_DEC, 1'b0, e[15:0], e[15:0], 1'b0);
    wr(4'h0, 16'h0006);
    op(2'h0, 4'h3, dag_pkg::MODE_REG_OFS, 1'b0, modf(w[3] + 16'h0006, 1'b0, x_mod), w[3],
       1'b0);
    wr(4'h3, 16'h101F);
    op(2'h0, 4'h3, dag_pkg::MODE_PRE_INC, 1'b0, 16'h1001, 16'h1001, 1'b0);
    wr(4'h2, 16'h0200);
    op(2'h0, 4'h2, dag_pkg::MODE_PLAIN, 1'b0, 16'h0200, 16'h0200, 1'b0);
    y_mod = '{en: 1'b1, sel: 4'h8, start: 16'h1800, stop: 16'h180F};
    wr(4'h8, 16'h180E);
    op(2'h2, 4'h8, dag_pkg::MODE_POST_INC, 1'b0, 16'h180E, 16'h0000, 1'b0);
    dual = 1'b1;
    op(2'h2, 4'h8, dag_pkg::MODE_POST_INC, 1'b0, 16'h180E,
       modf(16'h1810, 1'b0, y_mod), 1'b0);
    wr(4'h9, 16'h0100);
    op(2'h2, 4'h9, dag_pkg::MODE_PLAIN, 1'b0, 16'h0100, 16'h0100, 1'b0);
    brc = '{bitrev_enable: 1'b1, bitrev_pointer_select: 4'h5, bitrev_pivot: 15'h0008};
    wr(4'h8, 16'h180E);
    op(2'h2, 4'h8, dag_pkg::MODE_POST_INC, 1'b0, 16'h180E, 16'h1810, 1'b0);
    dual = 1'b0;
    x_mod = '{en: 1'b1, sel: 4'h6, start: 16'h3000, stop: 16'h300F};
    wr(4'h5, 16'h2000);
    repeat (4) op(2'h1, 4'h5, dag_pkg::MODE_POST_INC, 1'b0, w[5], brv(w[5]), 1'b1);
    op(2'h1, 4'h5, dag_pkg::MODE_PRE_INC, 1'b0, brv(w[5]), brv(w[5]), 1'b1);
    op(2'h1, 4'h5, dag_pkg::MODE_POST_INC, 1'b1, w[5], w[5] + 16'h0001, 1'b0);
    op(2'h1, 4'h5, dag_pkg::MODE_PLAIN, 1'b0, w[5], w[5], 1'b0);
    op(2'h0, 4'h5, dag_pkg::MODE_POST_INC, 1'b0, w[5], w[5] + 16'h0002, 1'b0);
    wr(4'h6, 16'h300E);
    op(2'h1, 4'h6, dag_pkg::MODE_POST_INC, 1'b0, 16'h300E, 16'h3010, 1'b0);
    wr(4'h6, 16'h300E);
    op(2'h0, 4'h6, dag_pkg::MODE_POST_INC, 1'b0, 16'h300E, 16'h3000, 1'b0);
    brc.bitrev_pointer_select = 4'hF;
    op(2'h1, 4'hF, dag_pkg::MODE_POST_INC, 1'b0, w[15], w[15] + 16'h0002, 1'b0);
    wr(4'h2, 16'h2000);
    op(2'h0, 4'h2, dag_pkg::MODE_PLAIN, 1'b0, 16'h2000, 16'h2000, 1'b0);
    chk({8'h00, mem_x}, {8'h00, 16'h7A5A});
    stk(1'b1);
    stk(1'b1);
    stk(1'b0);
    pc = seed[22:0];
    @(posedge clk_sys);
    #1;
    pg({1'b0, pc}, 4'h0);
    wr(4'h2, 16'h8ABC);
    op(2'h0, 4'h2, dag_pkg::MODE_PLAIN, 1'b0, 16'h8ABC, 16'h8ABC, 1'b0);
    psv_en = 1'b1;
    psv_pg = 8'hFF;
    op(2'h0, 4'h2, dag_pkg::MODE_PLAIN, 1'b0, 16'h8ABC, 16'h8ABC, 1'b0);
    pg({1'b0, 8'hFF, 15'h0ABC}, 4'h8);
    psv_en = 1'b0;
    tbl_rd = 1'b1;
    tbl_pg = 8'h80;
    op(2'h0, 4'h2, dag_pkg::MODE_PLAIN, 1'b0, 16'h8ABC, 16'h8ABC, 1'b0);
    pg({8'h80, 16'h8ABC}, 4'h5);
    tbl_rd = 1'b0;
    tbl_wr = 1'b1;
    tbl_pg = 8'h12;
    op(2'h0, 4'h2, dag_pkg::MODE_PLAIN, 1'b0, 16'h8ABC, 16'h8ABC, 1'b0);
    pg({8'h12, 16'h8ABC}, 4'h2);
    tbl_wr = 1'b0;
    summarize();
  end
endmodule
